/* hw/hbp_regs.svh */
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
`define HBP_OFF_MODE 12'h000
`define HBP_OFF_PWM_ROUTING_REG 12'h004
`define HBP_OFF_GEN 12'h008
`define HBP_OFF_CUR 12'h00C
`define HBP_OFF_ERR 12'h010
`define HBP_OFF_STAT 12'h014
`define HBP_OFF_CMD 12'h018
`define HBP_CLK_MHZ 40
`define HBP_EXEC_NS 3000
`define HBP_EXEC_CYC ((`HBP_EXEC_NS * `HBP_CLK_MHZ) / 1000)
`define HBP_CCP_ACT_RST 8'h10
`define HBP_CCP_FW_RST 8'h10
`define HBP_MODE_OFF 2'h0
`define HBP_MODE_LS 2'h1
`define HBP_MODE_HS 2'h2
`define HBP_MODE_OFF2 2'h3
`define HBP_AGC_NONE 2'h0
`define HBP_AGC_FIXED 2'h1
`endif

/* hw/hbp_pkg.sv */
package hbp_pkg;
    // gate drive phase of one switch
    typedef enum logic [2:0] {
        HBP_G_HOLD_OFF, HBP_G_STATIC_OFF, HBP_G_HARD_OFF, HBP_G_STATIC_ON, HBP_G_HOLD_ON,
        HBP_G_PRECHG, HBP_G_PREDCHG, HBP_G_PWM
    } hbp_gate_t;
    typedef enum logic [1:0] {HBP_IDLE, HBP_CCP, HBP_CHARGE, HBP_HOLD} hbp_state_t;
endpackage : hbp_pkg

/* hw/hbp_ctrl.sv */
`timescale 1ns/1ps
`include "hbp_regs.svh"
// Operation
// RULE1 - low-side static turn-on mirrors high-side turn-on with roles swapped
// RULE2 - mode 00 or 11 discharges both gates statically for active ccp time
// RULE3 - after that ccp time both gates drop to hold discharge level
// RULE4 - select rising edge is synchronised; command executes within 3 us
// RULE5 - three pwm channels, each fed from its own input pin
// RULE6 - disabled channel performs no pwm whatever its mapping
// RULE7 - bridge select uses low two bits, top bit ignored
// RULE8 - mode 01 routes pwm to low side, mode 10 to high side
// RULE9 - mode 00 or 11 on selected bridge means no pwm there
// RULE10 - host sets mode off, then select and enable, then pwm mode
// RULE11 - enabled channel with mode 00 keeps bridge high impedance
// RULE12 - bridge on several enabled channels: error, both off, conflict flag
// RULE13 - in pwm mode the freewheel switch turns on while active is off
// RULE14 - generator detect off: pwm switch active, opposite freewheels
// RULE15 - generator detect on: sample switch node at end of each ccp
// RULE16 - switch node between thresholds: switch about to turn on is active
// RULE17 - pwm always goes to the switch chosen by the drive mode
// RULE18 - short on-time or off-time falls back to pwm switch active
// RULE19 - agc 10 or 11 applies adaptive pre-charge and pre-discharge
// RULE20 - agc 00 skips pre-charge and pre-discharge
// RULE21 - agc 01 skips pre-charge, pre-discharges with fixed initial current
// RULE22 - static turn-on with opposite on waits ccp, charges, hard-off, holds
// RULE23 - hold select bit picks lower or higher hold current
// RULE24 - supply, thermal, vds, charge pump or enabled overcurrent fault: static off; the code has no overcurrent enable, any fault_oc counts
// RULE25 - pwm inputs are synchronised before any use
module hbp_ctrl #(
    parameter int NB = 4,
    parameter int NC = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic spi_select_n,
    input wire logic [NC-1:0] pwm_in,
    input wire logic [NB-1:0] sn_above_high,
    input wire logic [NB-1:0] sn_below_low,
    input wire logic fault_supply,
    input wire logic fault_temp,
    input wire logic fault_vds,
    input wire logic fault_cp,
    input wire logic fault_oc,
    output logic [NB-1:0] hs_on,
    output logic [NB-1:0] ls_on,
    output hbp_pkg::hbp_gate_t hs_gate [NB],
    output hbp_pkg::hbp_gate_t ls_gate [NB],
    output logic [NB-1:0] hs_is_active,
    output logic hold_high,
    output logic spi_error
);
    localparam int EXEC_CYC = `HBP_EXEC_CYC;

    // bus address phase
    logic wr_pend_ff;
    logic [11:0] addr_ff;
    logic rd_ok;
    assign rd_ok = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= rd_ok && hwrite;
            if (rd_ok) begin
                addr_ff <= haddr[11:0];
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // host registers; the mode and routing shadows are applied after select rise
    logic [2*NB-1:0] sh_mode_ff, mode_ff;
    logic [4*NC-1:0] sh_pwm_routing_reg_ff, pwm_routing_reg_ff;
    logic [3:0] gen_ff;
    logic [7:0] ccp_act_ff, ccp_fw_ff;
    logic [NB-1:0] err_ff;
    logic err_clr;
    assign err_clr = wr_pend_ff && (addr_ff == `HBP_OFF_ERR);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_mode_ff <= '0;
            sh_pwm_routing_reg_ff <= '0;
            gen_ff <= 4'h0;
            ccp_act_ff <= `HBP_CCP_ACT_RST;
            ccp_fw_ff <= `HBP_CCP_FW_RST;
        end else if (wr_pend_ff) begin
            if (addr_ff == `HBP_OFF_MODE) sh_mode_ff <= hwdata[2*NB-1:0];
            else if (addr_ff == `HBP_OFF_PWM_ROUTING_REG) sh_pwm_routing_reg_ff <= hwdata[4*NC-1:0];
            else if (addr_ff == `HBP_OFF_GEN) gen_ff <= hwdata[3:0];
            else if (addr_ff == `HBP_OFF_CUR) begin
                ccp_act_ff <= hwdata[7:0];
                ccp_fw_ff <= hwdata[15:8];
            end
        end
    end
    // gen_ff: [0] generator_detect_enable, [1] hold_current, [3:2] adaptive_gate_ctrl
    logic generator_detect_enable;
    logic [1:0] adaptive_gate_ctrl;
    assign generator_detect_enable = gen_ff[0];
    assign hold_high = gen_ff[1]; // RULE23
    assign adaptive_gate_ctrl = gen_ff[3:2];

    // select synchroniser and command execution delay
    logic [2:0] cs_sync_ff;
    logic [7:0] exec_cnt_ff;
    logic exec;
    always_ff @(posedge hclk or negedge hresetn) begin
        // resets to the idle high level, so no false rise follows reset
        if (!hresetn) cs_sync_ff <= 3'h7;
        else cs_sync_ff <= {cs_sync_ff[1:0], spi_select_n};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) exec_cnt_ff <= 8'h00;
        else if (cs_sync_ff[1] && !cs_sync_ff[2]) exec_cnt_ff <= 8'h01; // RULE4
        else if (exec_cnt_ff != 8'h00) exec_cnt_ff <= exec_cnt_ff + 8'h01;
    end
    assign exec = (exec_cnt_ff == 8'(EXEC_CYC - 8)); // RULE4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= '0;
            pwm_routing_reg_ff <= '0;
        end else if (exec) begin
            mode_ff <= sh_mode_ff;
            pwm_routing_reg_ff <= sh_pwm_routing_reg_ff;
        end
    end

    // pwm input synchroniser
    logic [NC-1:0] pwm_s1_ff, pwm_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_s1_ff <= '0;
            pwm_ff <= '0;
        end else begin
            pwm_s1_ff <= pwm_in; // RULE25
            pwm_ff <= pwm_s1_ff; // RULE5
        end
    end

    // channel to bridge routing
    logic [NB-1:0] br_pwm, br_lvl, conflict;
    always_comb begin
        logic [1:0] hits [NB];
        for (int b = 0; b < NB; b++) hits[b] = 2'h0;
        br_pwm = '0;
        br_lvl = '0;
        for (int c = 0; c < NC; c++) begin
            if (pwm_routing_reg_ff[4*c+3]) begin // RULE6
                // RULE7
                br_pwm[pwm_routing_reg_ff[4*c +: 2]] = 1'b1;
                br_lvl[pwm_routing_reg_ff[4*c +: 2]] = pwm_ff[c];
                if (hits[pwm_routing_reg_ff[4*c +: 2]] != 2'h3) hits[pwm_routing_reg_ff[4*c +: 2]]++;
            end
        end
        for (int b = 0; b < NB; b++) conflict[b] = hits[b] > 2'h1; // RULE12
    end
    // pwm_routing_reg layout per channel: [1:0] bridge, [2] ignored top bit, [3] enable

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) err_ff <= '0;
        else err_ff <= conflict | (err_clr ? ~hwdata[NB-1:0] & err_ff : err_ff); // RULE12
    end
    assign spi_error = |err_ff; // RULE12

    logic fault;
    assign fault = fault_supply | fault_temp | fault_vds | fault_cp | fault_oc; // RULE24

    // per-bridge sequencer
    hbp_pkg::hbp_state_t st_ff [NB];
    logic [7:0] tmr_ff [NB];
    logic [1:0] cur_mode_ff [NB];
    logic [NB-1:0] lvl_q_ff;
    // set while a bridge runs pwm, so leaving pwm restarts its static sequence
    logic [NB-1:0] was_pwm_ff;
    logic [7:0] on_len_ff [NB];
    logic [7:0] off_len_ff [NB];

    for (genvar b = 0; b < NB; b++) begin : g_br
        logic [1:0] m;
        logic pwm_mode, pwm_hs, want_hs, want_ls, edge_x;
        assign m = mode_ff[2*b +: 2];
        assign pwm_mode = br_pwm[b] && (m == `HBP_MODE_LS || m == `HBP_MODE_HS)
            && !conflict[b] && !fault; // RULE9 RULE11
        assign pwm_hs = (m == `HBP_MODE_HS); // RULE8 RULE17
        assign edge_x = br_lvl[b] ^ lvl_q_ff[b];
        // RULE13: freewheel switch is on while pwm switch is off
        assign want_hs = pwm_mode ? (pwm_hs ? br_lvl[b] : !br_lvl[b]) : 1'b0;
        assign want_ls = pwm_mode ? (pwm_hs ? !br_lvl[b] : br_lvl[b]) : 1'b0;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) lvl_q_ff[b] <= 1'b0;
            else lvl_q_ff[b] <= br_lvl[b];
        end

        // on and off time measurement
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                on_len_ff[b] <= 8'h00;
                off_len_ff[b] <= 8'h00;
            end else if (edge_x) begin
                if (br_lvl[b]) on_len_ff[b] <= 8'h00;
                else off_len_ff[b] <= 8'h00;
            end else if (br_lvl[b] && on_len_ff[b] != 8'hFF) begin
                on_len_ff[b] <= on_len_ff[b] + 8'h01;
            end else if (!br_lvl[b] && off_len_ff[b] != 8'hFF) begin
                off_len_ff[b] <= off_len_ff[b] + 8'h01;
            end
        end

        // active switch classification
        // sampled in the last cycle of each dead time, both switches off
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) hs_is_active[b] <= 1'b0;
            else if (!pwm_mode || !generator_detect_enable) hs_is_active[b] <= pwm_hs; // RULE14
            else if (st_ff[b] == hbp_pkg::HBP_CCP && tmr_ff[b] == 8'h01) begin // RULE15
                // a completed phase too short to judge keeps the pwm switch active
                if (br_lvl[b] ? off_len_ff[b] < ccp_act_ff : on_len_ff[b] < ccp_fw_ff)
                    hs_is_active[b] <= pwm_hs; // RULE18
                else if (sn_above_high[b]) hs_is_active[b] <= 1'b0;
                else if (sn_below_low[b]) hs_is_active[b] <= 1'b1;
                else hs_is_active[b] <= pwm_hs ? br_lvl[b] : !br_lvl[b]; // RULE16
            end
        end

        // static sequence and pwm switch control
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                st_ff[b] <= hbp_pkg::HBP_IDLE;
                tmr_ff[b] <= 8'h00;
                cur_mode_ff[b] <= `HBP_MODE_OFF;
                was_pwm_ff[b] <= 1'b0;
                hs_on[b] <= 1'b0;
                ls_on[b] <= 1'b0;
                hs_gate[b] <= hbp_pkg::HBP_G_HOLD_OFF;
                ls_gate[b] <= hbp_pkg::HBP_G_HOLD_OFF;
            end else if (fault || conflict[b]) begin // RULE24 RULE12
                st_ff[b] <= hbp_pkg::HBP_HOLD;
                cur_mode_ff[b] <= `HBP_MODE_OFF;
                was_pwm_ff[b] <= 1'b0;
                hs_on[b] <= 1'b0;
                ls_on[b] <= 1'b0;
                hs_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
                ls_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
            end else if (pwm_mode) begin
                was_pwm_ff[b] <= 1'b1;
                cur_mode_ff[b] <= m;
                // both switches off for the ccp time after every pwm edge
                if (edge_x || !was_pwm_ff[b] || m != cur_mode_ff[b]) begin
                    st_ff[b] <= hbp_pkg::HBP_CCP;
                    tmr_ff[b] <= ccp_act_ff;
                    hs_on[b] <= 1'b0;
                    ls_on[b] <= 1'b0;
                end else if (st_ff[b] == hbp_pkg::HBP_CCP && tmr_ff[b] > 8'h01) begin
                    tmr_ff[b] <= tmr_ff[b] - 8'h01;
                end else begin // RULE13
                    st_ff[b] <= hbp_pkg::HBP_HOLD;
                    hs_on[b] <= want_hs;
                    ls_on[b] <= want_ls;
                end
                // RULE19 RULE20 RULE21
                hs_gate[b] <= !pwm_hs ? hbp_pkg::HBP_G_PWM :
                    (!want_hs && adaptive_gate_ctrl != `HBP_AGC_NONE) ? hbp_pkg::HBP_G_PREDCHG :
                    (want_hs && adaptive_gate_ctrl[1]) ? hbp_pkg::HBP_G_PRECHG :
                    hbp_pkg::HBP_G_PWM;
                ls_gate[b] <= pwm_hs ? hbp_pkg::HBP_G_PWM :
                    (!want_ls && adaptive_gate_ctrl != `HBP_AGC_NONE) ? hbp_pkg::HBP_G_PREDCHG :
                    (want_ls && adaptive_gate_ctrl[1]) ? hbp_pkg::HBP_G_PRECHG :
                    hbp_pkg::HBP_G_PWM;
            end else if (m != cur_mode_ff[b] || was_pwm_ff[b]) begin // RULE6
                // a disabled channel hands the bridge back to its static mode
                was_pwm_ff[b] <= 1'b0;
                cur_mode_ff[b] <= m;
                tmr_ff[b] <= ccp_act_ff;
                if (m == `HBP_MODE_OFF || m == `HBP_MODE_OFF2) begin // RULE2
                    st_ff[b] <= hbp_pkg::HBP_CCP;
                    hs_on[b] <= 1'b0;
                    ls_on[b] <= 1'b0;
                    hs_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
                    ls_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
                end else if (hs_on[b] || ls_on[b]) begin // RULE22 RULE1
                    st_ff[b] <= hbp_pkg::HBP_CCP;
                    hs_on[b] <= 1'b0;
                    ls_on[b] <= 1'b0;
                    hs_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
                    ls_gate[b] <= hbp_pkg::HBP_G_STATIC_OFF;
                end else begin
                    st_ff[b] <= hbp_pkg::HBP_CHARGE;
                    hs_on[b] <= (m == `HBP_MODE_HS);
                    ls_on[b] <= (m == `HBP_MODE_LS);
                    hs_gate[b] <= (m == `HBP_MODE_HS) ? hbp_pkg::HBP_G_STATIC_ON : hbp_pkg::HBP_G_HARD_OFF;
                    ls_gate[b] <= (m == `HBP_MODE_LS) ? hbp_pkg::HBP_G_STATIC_ON : hbp_pkg::HBP_G_HARD_OFF;
                end
            end else if (tmr_ff[b] > 8'h01) begin
                tmr_ff[b] <= tmr_ff[b] - 8'h01;
            end else if (st_ff[b] == hbp_pkg::HBP_CCP) begin
                tmr_ff[b] <= ccp_act_ff;
                if (m == `HBP_MODE_OFF || m == `HBP_MODE_OFF2) begin // RULE3
                    st_ff[b] <= hbp_pkg::HBP_HOLD;
                    hs_gate[b] <= hbp_pkg::HBP_G_HOLD_OFF;
                    ls_gate[b] <= hbp_pkg::HBP_G_HOLD_OFF;
                end else begin // RULE22 RULE1
                    st_ff[b] <= hbp_pkg::HBP_CHARGE;
                    hs_on[b] <= (m == `HBP_MODE_HS);
                    ls_on[b] <= (m == `HBP_MODE_LS);
                    hs_gate[b] <= (m == `HBP_MODE_HS) ? hbp_pkg::HBP_G_STATIC_ON : hbp_pkg::HBP_G_HARD_OFF;
                    ls_gate[b] <= (m == `HBP_MODE_LS) ? hbp_pkg::HBP_G_STATIC_ON : hbp_pkg::HBP_G_HARD_OFF;
                end
            end else if (st_ff[b] == hbp_pkg::HBP_CHARGE) begin // RULE22
                st_ff[b] <= hbp_pkg::HBP_HOLD;
                hs_gate[b] <= hs_on[b] ? hbp_pkg::HBP_G_HOLD_ON : hbp_pkg::HBP_G_HOLD_OFF;
                ls_gate[b] <= ls_on[b] ? hbp_pkg::HBP_G_HOLD_ON : hbp_pkg::HBP_G_HOLD_OFF;
            end
        end
    end

    // read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (rd_ok && !hwrite) begin
            if (haddr[11:0] == `HBP_OFF_MODE) hrdata <= 32'(sh_mode_ff);
            else if (haddr[11:0] == `HBP_OFF_PWM_ROUTING_REG) hrdata <= 32'(sh_pwm_routing_reg_ff);
            else if (haddr[11:0] == `HBP_OFF_GEN) hrdata <= 32'(gen_ff);
            else if (haddr[11:0] == `HBP_OFF_CUR) hrdata <= {16'h0000, ccp_fw_ff, ccp_act_ff};
            else if (haddr[11:0] == `HBP_OFF_ERR) hrdata <= 32'(err_ff);
            else if (haddr[11:0] == `HBP_OFF_STAT) hrdata <= {16'h0000, 4'(hs_is_active), 4'(br_pwm),
                4'(hs_on), 4'(ls_on)};
            else hrdata <= 32'h0000_0000;
        end
    end
endmodule : hbp_ctrl

/* sim/hbp_ctrl_assertions.sv */
`timescale 1ns/1ps
module hbp_ctrl_assertions #(parameter int NB = 4) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic fault_supply,
    input wire logic fault_temp,
    input wire logic fault_vds,
    input wire logic fault_cp,
    input wire logic fault_oc,
    input wire logic [NB-1:0] hs_on,
    input wire logic [NB-1:0] ls_on,
    input hbp_pkg::hbp_gate_t hs_gate [NB],
    input hbp_pkg::hbp_gate_t ls_gate [NB],
    input wire logic hold_high,
    input wire logic spi_error
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [5:0] clr_seen_ff;
    // recent writes to the conflict flags, the only way the error may drop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) clr_seen_ff <= 6'h00;
        else clr_seen_ff <= {clr_seen_ff[4:0], hsel && hready && htrans[1] && hwrite
            && haddr[11:0] == 12'h010};
    end
    sequence s_wr_gen;
        hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h008 ##1 1'b1;
    endsequence
    sequence s_both_static;
        hs_gate[2] == hbp_pkg::HBP_G_STATIC_OFF && ls_gate[2] == hbp_pkg::HBP_G_STATIC_OFF;
    endsequence
    property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
    property p_hold; s_wr_gen |=> hold_high == $past(hwdata[1]); endproperty
    property p_no_shoot; (hs_on & ls_on) == '0; endproperty
    property p_fault;
        (fault_supply || fault_temp || fault_vds || fault_cp || fault_oc) [*6]
            |-> (hs_on | ls_on) == '0;
    endproperty
    property p_off_hold;
        s_both_static ##1 hs_gate[2] == hbp_pkg::HBP_G_HOLD_OFF
            |-> ls_gate[2] == hbp_pkg::HBP_G_HOLD_OFF;
    endproperty
    property p_hs_charge;
        hs_gate[2] == hbp_pkg::HBP_G_STATIC_ON |-> ls_gate[2] == hbp_pkg::HBP_G_HARD_OFF;
    endproperty
    property p_ls_charge;
        ls_gate[2] == hbp_pkg::HBP_G_STATIC_ON |-> hs_gate[2] == hbp_pkg::HBP_G_HARD_OFF;
    endproperty
    property p_err_sticky; $fell(spi_error) |-> clr_seen_ff != 6'h00; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
    a_hold: assert property (p_hold) else $error("hold select wrong");
    a_no_shoot: assert property (p_no_shoot) else $error("shoot-through");
    a_fault: assert property (p_fault) else $error("switch on in fault");
    a_off_hold: assert property (p_off_hold) else $error("gates not to hold");
    a_hs_charge: assert property (p_hs_charge) else $error("no hard off");
    a_ls_charge: assert property (p_ls_charge) else $error("no hard off");
    a_err_sticky: assert property (p_err_sticky) else $error("error dropped");
endmodule : hbp_ctrl_assertions
bind hbp_ctrl hbp_ctrl_assertions #(.NB(NB)) i_hbp_ctrl_assertions (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .fault_supply(fault_supply), .fault_temp(fault_temp),
    .fault_vds(fault_vds), .fault_cp(fault_cp), .fault_oc(fault_oc), .hs_on(hs_on),
    .ls_on(ls_on), .hs_gate(hs_gate), .ls_gate(ls_gate), .hold_high(hold_high),
    .spi_error(spi_error)
);

/* sim/hbp_bridge_model.sv */
`timescale 1ns/1ps
module hbp_bridge_model #(parameter int NB = 4) (
    input wire logic hclk,
    input wire logic [NB-1:0] hs_on,
    input wire logic [NB-1:0] ls_on,
    input wire logic [NB-1:0] cur_out,
    output logic [NB-1:0] sn_above_high,
    output logic [NB-1:0] sn_below_low
);
    logic [NB-1:0] node_hi;
    // open bridge: motor current clamps the node through a body diode
    always_comb node_hi = hs_on | (~ls_on & ~cur_out);
    always_ff @(posedge hclk) begin
        sn_above_high <= node_hi;
        sn_below_low <= ~node_hi;
    end
endmodule : hbp_bridge_model

/* sim/hbp_ctrl_bench.sv */
`timescale 1ns/1ps
`include "hbp_regs.svh"
module hbp_ctrl_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic spi_select_n = 1'b1;
    logic hready, hreadyout, hresp, hold_high, spi_error;
    logic [1:0] htrans = 2'h0;
    logic [2:0] pwm_in = 3'h0;
    logic [4:0] flt = 5'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] hs_on, ls_on, hs_act, above, below;
    logic [3:0] cur_out = 4'hF;
    hbp_pkg::hbp_gate_t hs_gate [4];
    hbp_pkg::hbp_gate_t ls_gate [4];
    int n_fail = 0;
    int n_compared = 0;
    int mode [4] = '{0, 0, 0, 0};
    int sel [3] = '{0, 0, 0};
    int en [3] = '{0, 0, 0};
    int b, k;
    always #12.5 hclk = ~hclk;
    assign hready = hreadyout;
    hbp_ctrl i_hbp_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .spi_select_n(spi_select_n), .pwm_in(pwm_in),
        .sn_above_high(above), .sn_below_low(below), .fault_supply(flt[0]),
        .fault_temp(flt[1]), .fault_vds(flt[2]), .fault_cp(flt[3]), .fault_oc(flt[4]),
        .hs_on(hs_on), .ls_on(ls_on), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .hs_is_active(hs_act), .hold_high(hold_high), .spi_error(spi_error)
    );
    hbp_bridge_model i_hbp_bridge_model (
        .hclk(hclk), .hs_on(hs_on), .ls_on(ls_on), .cur_out(cur_out),
        .sn_above_high(above), .sn_below_low(below)
    );
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task results;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task commit;
        @(posedge hclk);
        spi_select_n <= 1'b0;
        @(posedge hclk);
        spi_select_n <= 1'b1;
    endtask : commit
    // expected {hs_on, ls_on} for the pwm pin levels
    function automatic logic [7:0] expv(input logic [2:0] pin);
        int n;
        int ch;
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 4; i++) begin
            n = 0;
            ch = 0;
            for (int c = 0; c < 3; c++) begin
                if (en[c] != 0 && sel[c] % 4 == i) begin
                    n++;
                    ch = c;
                end
            end
            if (mode[i] == 1 || mode[i] == 2) begin
                if (n == 0) r[i + 4 * (mode[i] - 1)] = 1'b1;
                else if (n == 1) r[i + 4 * int'((mode[i] == 2) ^ !pin[ch])] = 1'b1;
            end
        end
        return r;
    endfunction : expv
    task cfg;
        logic [31:0] mw;
        logic [31:0] pw;
        mw = 32'h0;
        pw = 32'h0;
        for (int i = 0; i < 4; i++) mw[2 * i +: 2] = 2'(mode[i]);
        for (int i = 0; i < 3; i++) pw[4 * i +: 4] = {en[i][0], 3'(sel[i])};
        bus(1'b1, `HBP_OFF_MODE, mw);
        bus(1'b1, `HBP_OFF_PWM_ROUTING_REG, pw);
        commit();
        repeat (200) @(posedge hclk);
    endtask : cfg
    task outs(input logic [2:0] pin);
        pwm_in <= pin;
        repeat (60) @(posedge hclk);
        chk(32'({hs_on, ls_on}), 32'(expv(pin)));
    endtask : outs
    initial begin
        void'($urandom(32'hA469A777));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `HBP_OFF_CUR, 32'h0);
        chk(rd, 32'h00001010);
        bus(1'b0, 12'h0FC, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `HBP_OFF_GEN, 32'h2);
        @(posedge hclk);
        chk(32'(hold_high), 32'h1);
        bus(1'b1, `HBP_OFF_GEN, 32'h0);
        $display("test reset and hold done");
        for (int c = 0; c < 3; c++) begin
            for (int m = 1; m < 3; m++) begin
                b = $urandom_range(3);
                mode = '{0, 0, 0, 0};
                en = '{0, 0, 0};
                cfg();
                sel[c] = b + 4 * $urandom_range(1);
                en[c] = 1;
                cfg();
                outs(3'h7);
                mode[b] = m;
                cfg();
                outs(3'(1 << c));
                outs(~3'(1 << c));
                chk(32'(hs_act[b]), 32'(m == 2));
                en[c] = 0;
                cfg();
                outs(3'(1 << c));
            end
        end
        $display("test mapping done");
        mode = '{0, 2, 0, 0};
        en = '{1, 1, 0};
        sel = '{1, 5, 0};
        cfg();
        outs(3'h3);
        chk(32'(spi_error), 32'h1);
        bus(1'b0, `HBP_OFF_ERR, 32'h0);
        chk(32'(rd[3:0]), 32'h2);
        en[1] = 0;
        cfg();
        bus(1'b1, `HBP_OFF_ERR, 32'hF);
        repeat (2) @(posedge hclk);
        chk(32'(spi_error), 32'h0);
        $display("test conflict done");
        bus(1'b1, `HBP_OFF_CUR, 32'h0000100B);
        mode = '{0, 0, 1, 0};
        en = '{0, 0, 0};
        cfg();
        for (int s = 2; s > 0; s--) begin
            mode[2] = s;
            cfg();
            chk(32'({hs_on, ls_on}), 32'(expv(3'h0)));
            bus(1'b1, `HBP_OFF_MODE, (s == 1) ? 32'h30 : 32'h0);
            commit();
            k = 0;
            while (hs_gate[2] !== hbp_pkg::HBP_G_STATIC_OFF && k < 200) begin
                @(posedge hclk);
                k++;
            end
            chk(32'(k <= 120), 32'h1);
            chk(32'(ls_gate[2]), 32'(hbp_pkg::HBP_G_STATIC_OFF));
            k = 0;
            while (hs_gate[2] === hbp_pkg::HBP_G_STATIC_OFF && k < 300) begin
                @(posedge hclk);
                k++;
            end
            chk(k, 32'hB);
            chk(32'({hs_gate[2], ls_gate[2]}),
                32'({hbp_pkg::HBP_G_HOLD_OFF, hbp_pkg::HBP_G_HOLD_OFF}));
            mode[2] = 0;
        end
        $display("test turn-off done");
        bus(1'b1, `HBP_OFF_GEN, 32'h5);
        mode = '{2, 0, 0, 0};
        en = '{1, 0, 0};
        sel[0] = 4;
        cfg();
        for (int d = 0; d < 2; d++) begin
            cur_out <= 4'(d * 15);
            repeat (3) begin
                outs(3'h1);
                outs(3'h0);
            end
            chk(32'(hs_act[0]), 32'(d));
        end
        chk(32'(hs_gate[0]), 32'(hbp_pkg::HBP_G_PREDCHG));
        $display("test generator done");
        mode = '{2, 2, 1, 1};
        en = '{0, 0, 0};
        cfg();
        for (int f = 0; f < 5; f++) begin
            flt <= 5'(1 << f);
            repeat (8) @(posedge hclk);
            chk(32'({hs_on, ls_on}), 32'h0);
            flt <= 5'h00;
            repeat (4) @(posedge hclk);
        end
        $display("test faults done");
        results();
    end
    // the tests take about 9000 cycles
    initial begin
        repeat (40000) @(posedge hclk);
        n_fail++;
        results();
    end
endmodule : hbp_ctrl_bench
